// ---- shared/mfc_regs.vh ----
`ifndef MFC_REGS_VH
`define MFC_REGS_VH
// Register offsets (byte addresses on the plain port)
`define MFC_ADDR_ACT_EN 8'h24
`define MFC_ADDR_THR_HIGH 8'h25
`define MFC_ADDR_THR_LOW 8'h26
`define MFC_ADDR_PERSIST 8'h27
`define MFC_ADDR_FILTER 8'h28
`define MFC_ADDR_WATERMARK 8'h29
`define MFC_ADDR_INT_MAP 8'h2A
`define MFC_ADDR_IRQ_STATUS 8'h30
`define MFC_ADDR_IRQ_MASK 8'h31
`define MFC_ADDR_MOTION_COUNT 8'h32
// Reset values
`define MFC_RST_THR 8'h00
`define MFC_RST_PERSIST 8'h01
`define MFC_RST_FILTER 8'h00
`define MFC_RST_WATERMARK 8'h60
`define MFC_RST_ZERO 8'h00
`define MFC_RST_ACT_EN 3'h0
`define MFC_RST_FILTER_FIELD 7'h00
`define MFC_RST_WM_FIELD 7'h60
`define MFC_RST_MASK 2'h0
`define MFC_RST_STATUS 2'h0
// Field positions
`define MFC_HPF_MSB 6
`define MFC_HPF_LSB 4
`define MFC_RATE_MSB 3
`define MFC_RATE_LSB 0
`define MFC_WM_MSB 6
`define MFC_MAP_FULL_PIN1 1
`define MFC_THR_SAMPLE_MSB 18
`define MFC_THR_SAMPLE_LSB 3
// Interrupt status bits and the high-pass bypass code
`define MFC_ST_ACTIVITY 0
`define MFC_ST_FULL 1
`define MFC_HPF_BYPASS 3'h0
`endif

// ---- hdl/mfc_config_regs.v ----
`timescale 1ns/10ps
`include "mfc_regs.vh"
module mfc_config_regs #(
  parameter SAMPLE_W = 20,
  parameter FIFO_CNT_W = 7
) (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire sample_valid,
  input wire [SAMPLE_W-1:0] x_axis_sample,
  input wire [SAMPLE_W-1:0] y_axis_sample,
  input wire [SAMPLE_W-1:0] z_axis_sample,
  input wire [FIFO_CNT_W-1:0] fifo_count,
  output wire [2:0] highpass_cutoff_sel,
  output wire highpass_bypass,
  output wire [3:0] rate_lowpass_sel,
  output reg activity_pulse,
  output wire fifo_full,
  output wire irq_pin_one,
  output wire irq
);
  // Stored configuration; reserved bits are not kept and read as zero
  reg [2:0] act_en_reg;
  reg [7:0] thr_high_reg;
  reg [7:0] thr_low_reg;
  reg [7:0] persist_reg;
  reg [6:0] filter_reg;
  reg [6:0] watermark_reg;
  reg [7:0] int_map_reg;
  reg [1:0] mask_reg;
  // Detector, interrupt and read-back state
  reg [1:0] status_reg;
  reg [7:0] motion_count_reg;
  reg full_q_reg;
  reg [1:0] status_next;
  reg [7:0] count_next;
  reg [7:0] rdata_next;
  reg act_now;
  // Axis view for the comparators
  wire [15:0] activity_threshold;
  wire x_motion_include;
  wire y_motion_include;
  wire z_motion_include;
  wire [2:0] axis_include;
  wire [3*SAMPLE_W-1:0] axis_bus;
  wire [2:0] above;
  // Flags and strobes
  wire run_full;
  wire full_rise;
  wire status_rd;
  // Decoded write enables
  wire wr_act_en;
  wire wr_thr_high;
  wire wr_thr_low;
  wire wr_persist;
  wire wr_filter;
  wire wr_watermark;
  wire wr_int_map;
  wire wr_mask;

  // Magnitude of a signed sample at the threshold's weight; the most negative
  // code has no positive twin, so it saturates instead of folding to zero
  function [15:0] mfc_mag;
    input [SAMPLE_W-1:0] s;
    reg [SAMPLE_W-1:0] a;
    begin
      a = s[SAMPLE_W-1] ? (~s + {{(SAMPLE_W-1){1'h0}}, 1'h1}) : s;
      if (a[SAMPLE_W-1]) begin
        mfc_mag = 16'hFFFF;
      end else begin
        mfc_mag = a[`MFC_THR_SAMPLE_MSB:`MFC_THR_SAMPLE_LSB];
      end
    end
  endfunction

  // Register select, shared by every write enable and the read-clear strobe
  function mfc_hit;
    input [7:0] a;
    input [7:0] offset;
    begin
      mfc_hit = (a == offset);
    end
  endfunction

  // Write enables and the read-clear strobe, one decode each
  assign wr_act_en = wr_stb && mfc_hit(addr, `MFC_ADDR_ACT_EN);
  assign wr_thr_high = wr_stb && mfc_hit(addr, `MFC_ADDR_THR_HIGH);
  assign wr_thr_low = wr_stb && mfc_hit(addr, `MFC_ADDR_THR_LOW);
  assign wr_persist = wr_stb && mfc_hit(addr, `MFC_ADDR_PERSIST);
  assign wr_filter = wr_stb && mfc_hit(addr, `MFC_ADDR_FILTER);
  assign wr_watermark = wr_stb && mfc_hit(addr, `MFC_ADDR_WATERMARK);
  assign wr_int_map = wr_stb && mfc_hit(addr, `MFC_ADDR_INT_MAP);
  assign wr_mask = wr_stb && mfc_hit(addr, `MFC_ADDR_IRQ_MASK);
  assign status_rd = rd_stb && mfc_hit(addr, `MFC_ADDR_IRQ_STATUS);

  // Threshold bytes and axis enables as the comparators see them
  assign activity_threshold = {thr_high_reg, thr_low_reg};
  assign x_motion_include = act_en_reg[0];
  assign y_motion_include = act_en_reg[1];
  assign z_motion_include = act_en_reg[2];
  assign axis_include = {z_motion_include, y_motion_include, x_motion_include};
  assign axis_bus = {z_axis_sample, y_axis_sample, x_axis_sample};

  // Per-axis strict compare; a magnitude equal to the threshold does not count
  // Disabled axes are masked here, before the run counter sees them
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_axis
      assign above[gi] = axis_include[gi] &&
        (mfc_mag(axis_bus[gi*SAMPLE_W +: SAMPLE_W]) > activity_threshold);
    end
  endgenerate

  // Filter fields for the signal path; the filters themselves live outside
  assign highpass_cutoff_sel = filter_reg[`MFC_HPF_MSB:`MFC_HPF_LSB];
  assign highpass_bypass = (highpass_cutoff_sel == `MFC_HPF_BYPASS);
  assign rate_lowpass_sel = filter_reg[`MFC_RATE_MSB:`MFC_RATE_LSB];

  // Watermark compare; a zero watermark never fires, keeping a bad write quiet
  // The compare is a level; the status bit catches only its rising edge
  assign fifo_full = (watermark_reg != 7'h00) &&
    ({7'h00, fifo_count} >= {{FIFO_CNT_W{1'h0}}, watermark_reg});
  assign full_rise = fifo_full && !full_q_reg;
  assign irq_pin_one = fifo_full && int_map_reg[`MFC_MAP_FULL_PIN1];
  assign irq = |(status_reg & mask_reg);

  // Consecutive-event counter; a sample with no enabled axis above resets the run
  // The run saturates at its top so a long burst cannot wrap back to zero
  assign run_full = (motion_count_reg == 8'hFF);
  always @* begin
    count_next = motion_count_reg;
    act_now = 1'h0;
    if (sample_valid) begin
      if (|above) begin
        if (!run_full) begin
          count_next = motion_count_reg + 8'h01;
        end
        // A saturated run must not wrap round onto a persistence of zero
        if (!run_full && ((motion_count_reg + 8'h01) == persist_reg)) begin
          act_now = 1'h1;
        end
      end else begin
        count_next = 8'h00;
      end
    end
  end

  // Sticky status: a set in the same cycle as the read-clear wins
  // so an event landing on the clearing read is never lost
  always @* begin
    status_next = status_rd ? `MFC_RST_STATUS : status_reg;
    if (act_now) begin
      status_next[`MFC_ST_ACTIVITY] = 1'h1;
    end
    if (full_rise) begin
      status_next[`MFC_ST_FULL] = 1'h1;
    end
  end

  // Axis enables
  // Changing the enables mid-run leaves the run counter as it is
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      act_en_reg <= `MFC_RST_ACT_EN;
    end else if (wr_act_en) begin
      act_en_reg <= wdata[2:0];
    end
  end

  // Threshold high byte
  // No shadowing: between the two byte writes the compare sees a mixed value
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      thr_high_reg <= `MFC_RST_THR;
    end else if (wr_thr_high) begin
      thr_high_reg <= wdata;
    end
  end

  // Threshold low byte
  // Written on its own, like the high byte
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      thr_low_reg <= `MFC_RST_THR;
    end else if (wr_thr_low) begin
      thr_low_reg <= wdata;
    end
  end

  // Persistence count
  // A persistence of zero never matches a run, so it never fires
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      persist_reg <= `MFC_RST_PERSIST;
    end else if (wr_persist) begin
      persist_reg <= wdata;
    end
  end

  // Filter settings, bit 7 reserved
  // Undocumented codes are stored as written; the signal path must cope
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filter_reg <= `MFC_RST_FILTER_FIELD;
    end else if (wr_filter) begin
      filter_reg <= wdata[6:0];
    end
  end

  // Watermark, bit 7 reserved
  // The reset value 0x60 sits below the top of the range, so a count of 96 or more fires by default
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      watermark_reg <= `MFC_RST_WM_FIELD;
    end else if (wr_watermark) begin
      watermark_reg <= wdata[`MFC_WM_MSB:0];
    end
  end

  // Interrupt map
  // Only the pin-one watermark route is used here; the other bits are kept
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_map_reg <= `MFC_RST_ZERO;
    end else if (wr_int_map) begin
      int_map_reg <= wdata;
    end
  end

  // Interrupt mask, same layout as the status
  // Masking hides a bit from the interrupt line but not from a status read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= `MFC_RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= wdata[1:0];
    end
  end

  // Detector state and the registered activity pulse
  // The pulse lasts one cycle; the sticky status bit keeps it for software
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= `MFC_RST_STATUS;
      motion_count_reg <= `MFC_RST_ZERO;
      full_q_reg <= 1'h0;
      activity_pulse <= 1'h0;
    end else begin
      status_reg <= status_next;
      motion_count_reg <= count_next;
      full_q_reg <= fifo_full;
      activity_pulse <= act_now;
    end
  end

  // Read mux; unmapped addresses and reserved bits read as zero
  // Status reads back its value from before the clear takes effect
  always @* begin
    rdata_next = `MFC_RST_ZERO;
    case (addr)
      `MFC_ADDR_ACT_EN: rdata_next = {5'h00, act_en_reg};
      `MFC_ADDR_THR_HIGH: rdata_next = thr_high_reg;
      `MFC_ADDR_THR_LOW: rdata_next = thr_low_reg;
      `MFC_ADDR_PERSIST: rdata_next = persist_reg;
      `MFC_ADDR_FILTER: rdata_next = {1'h0, filter_reg};
      `MFC_ADDR_WATERMARK: rdata_next = {1'h0, watermark_reg};
      `MFC_ADDR_INT_MAP: rdata_next = int_map_reg;
      `MFC_ADDR_IRQ_STATUS: rdata_next = {6'h00, status_reg};
      `MFC_ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
      `MFC_ADDR_MOTION_COUNT: rdata_next = motion_count_reg;
      default: rdata_next = `MFC_RST_ZERO;
    endcase
  end

  // Read data stand only in the cycle after the strobe, then drop to zero
  // so a stale byte never lingers on the port
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `MFC_RST_ZERO;
    end else if (rd_stb) begin
      rdata <= rdata_next;
    end else begin
      rdata <= `MFC_RST_ZERO;
    end
  end
endmodule

// ---- bench/mfc_chk.sv ----
`timescale 1ns/10ps
module mfc_chk #(
  parameter FIFO_CNT_W = 7
) (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire sample_valid,
  input wire [FIFO_CNT_W-1:0] fifo_count,
  input wire [2:0] highpass_cutoff_sel,
  input wire highpass_bypass,
  input wire [3:0] rate_lowpass_sel,
  input wire activity_pulse,
  input wire fifo_full,
  input wire irq_pin_one
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // A write to the filter settings byte
  sequence s_filt_wr;
    wr_stb && addr == 8'h28;
  endsequence
  // Read data must not linger, else software sees stale bytes
  a_rd_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00) else $error("rdata not idle");
  a_rate_write: assert property (s_filt_wr |=> {4'h0, rate_lowpass_sel} == ($past(wdata) & 8'h0F))
    else $error("rate field wrong");
  a_hpf_write: assert property (s_filt_wr |=> {1'b0, highpass_cutoff_sel, 4'h0} == ($past(wdata) & 8'h70))
    else $error("cutoff field wrong");
  a_rate_hold: assert property (!$past(wr_stb) |-> $stable(rate_lowpass_sel)) else $error("rate moved");
  a_bypass_dec: assert property (highpass_bypass == (highpass_cutoff_sel == 3'h0)) else $error("bypass");
  a_pin_gated: assert property (irq_pin_one |-> fifo_full) else $error("pin without full");
  a_full_empty: assert property (fifo_count == 0 |-> !fifo_full) else $error("full when empty");
  a_pulse_single: assert property (activity_pulse |=> !activity_pulse) else $error("pulse too long");
  a_pulse_cause: assert property (activity_pulse |-> $past(sample_valid)) else $error("pulse no sample");
endmodule
bind mfc_config_regs mfc_chk #(.FIFO_CNT_W(FIFO_CNT_W)) u_chk (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sample_valid(sample_valid),
  .fifo_count(fifo_count), .highpass_cutoff_sel(highpass_cutoff_sel), .highpass_bypass(highpass_bypass),
  .rate_lowpass_sel(rate_lowpass_sel), .activity_pulse(activity_pulse), .fifo_full(fifo_full),
  .irq_pin_one(irq_pin_one));

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg sample_valid = 1'b0;
  reg [19:0] xs = 20'h00000;
  reg [19:0] ys = 20'h00000;
  reg [19:0] zs = 20'h00000;
  reg [6:0] fifo_count = 7'h00;
  reg [7:0] rv;
  wire [7:0] rdata;
  wire [2:0] hp_sel;
  wire [3:0] rate_sel;
  wire hp_byp, act_p, full, pin1, irq;
  logic [7:0] rst_v [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h60};
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // Each axis has its own stimulus so the enables can be told apart
  mfc_config_regs dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .sample_valid(sample_valid), .x_axis_sample(xs), .y_axis_sample(ys), .z_axis_sample(zs),
    .fifo_count(fifo_count), .highpass_cutoff_sel(hp_sel), .highpass_bypass(hp_byp), .rate_lowpass_sel(rate_sel),
    .activity_pulse(act_p), .fifo_full(full), .irq_pin_one(pin1), .irq(irq));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well beyond the under one hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    #1; // Let the write land before the caller looks at outputs
  endtask
  // Data stands only in the cycle after the strobe edge
  task rd(input [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 rv = rdata;
  endtask
  task smp(input [19:0] x, input [19:0] y, input [19:0] z, input exp);
    @(posedge ref_clk);
    xs <= x;
    ys <= y;
    zs <= z;
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    #1 `CHK(act_p, exp)
  endtask
  task fifo(input [6:0] n, input exp);
    @(posedge ref_clk);
    fifo_count <= n;
    #1 `CHK(full, exp)
  endtask
  task t_reset;
    for (int i = 0; i < 5; i++) begin
      rd(8'h25 + i);
      `CHK(rv, rst_v[i])
    end
    `CHK(hp_byp, 1'b1)
    $display("t_reset done");
  endtask
  task t_regs;
    wr(8'h25, 8'h12);
    wr(8'h26, 8'h34);
    rd(8'h25);
    `CHK(rv, 8'h12)
    rd(8'h26);
    `CHK(rv, 8'h34)
    wr(8'h28, 8'hE5);
    rd(8'h28);
    `CHK(rv, 8'h65)
    `CHK({hp_byp, hp_sel, rate_sel}, 8'h65)
    wr(8'h28, 8'h0A);
    `CHK({hp_byp, hp_sel, rate_sel}, 8'h8A)
    wr(8'h29, 8'h85);
    rd(8'h29);
    `CHK(rv, 8'h05)
    fifo(7'h04, 1'b0);
    fifo(7'h05, 1'b1);
    wr(8'h2A, 8'h02);
    `CHK(pin1, 1'b1)
    wr(8'h2A, 8'h00);
    `CHK(pin1, 1'b0)
    $display("t_regs done");
  endtask
  // Threshold 0x0010, persistence two, only x enabled
  task t_act;
    wr(8'h24, 8'h01);
    wr(8'h25, 8'h00);
    wr(8'h26, 8'h10);
    wr(8'h27, 8'h02);
    wr(8'h31, 8'h01);
    rd(8'h30);
    `CHK(rv, 8'h02)
    smp(20'h00080, 20'h0, 20'h0, 1'b0);
    smp(20'h00088, 20'h0, 20'h0, 1'b0);
    smp(20'h00000, 20'h7FFF8, 20'h0, 1'b0);
    smp(20'h00088, 20'h0, 20'h0, 1'b0);
    smp(20'hFFF78, 20'h0, 20'h0, 1'b1);
    `CHK(irq, 1'b1)
    rd(8'h30);
    `CHK(rv, 8'h01)
    `CHK(irq, 1'b0)
    // Z only: an x above threshold no longer counts and breaks the run
    wr(8'h24, 8'h04);
    smp(20'h00088, 20'h0, 20'h0, 1'b0);
    smp(20'h0, 20'h0, 20'h00088, 1'b0);
    smp(20'h0, 20'h0, 20'hFFF78, 1'b1);
    `CHK(irq, 1'b1)
    $display("t_act done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_act();
    give_verdict();
  end
endmodule
